// ==== core/sync_blank_regs.vh ====
// register offsets, field positions, reset values and timing counts of the sync front end
`ifndef SYNC_BLANK_REGS_VH
`define SYNC_BLANK_REGS_VH

// register offsets (byte addresses)
`define CTRL_ADDR        8'h00
`define REF_ADDR         8'h04
`define STAT_ADDR        8'h08
`define PERIOD_ADDR      8'h0C

// control register fields
`define CTRL_CLAMP_BIT   0
`define CTRL_VBLEN_BIT   1
`define CTRL_BLKOFF_BIT  2
`define CTRL_RAMP_BIT    3
`define CTRL_RESET       4'h0

// reference setting for the vertical integrator
`define REF_RESET        8'h20

// status register fields
`define STAT_STATE_LSB   0
`define STAT_PROT_BIT    4
`define STAT_CBLANK_BIT  5
`define STAT_HPOL_BIT    6
`define STAT_VPOL_BIT    7
`define STAT_PIN_BIT     8
`define STAT_RAMP_BIT    9

// timing
`define CLK_PERIOD_NS    25
`define CLAMP_NS         1000
`define CLAMP_CYCLES     ((`CLAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OV_FILTER_NS     2000
`define OV_CYCLES        ((`OV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VBLANK_SHORT     16'h0014
`define VBLANK_LONG      16'h0028
`define SOFT_LINES       8'h20
`define FREQ_TOL_DIV     25
`define SEARCH_STEP      16'h0001
`define FMIN_PERIOD      1408
`define RAMP_CYCLES      200000

`endif

// ==== core/sync_blank_lock_status.v ====
// sync polarity, vertical extraction, sandcastle, lock loop and lock status pin
// Operation
// - detect horizontal or composite sync polarity and output fixed-polarity pulses
// - normalised hsync feeds vertical extractor, phase detector and frequency loop
// - extract vertical sync by integration scaled by reference; it triggers vertical
// - normalise separate vertical sync polarity the same way
// - OR extracted and separate vertical sync into the vertical trigger
// - sandcastle output: upper level clamp, lower level vertical blanking
// - clamp starts on sync leading or trailing edge per control bit
// - clamp width fixed by internal one-shot, not by sync width
// - vertical blanking starts on vertical sync, ends at scan start
// - two vertical blanking lengths selected by control bit
// - continuous blanking on ramp hold, search unlock, no flyback, guard, low supply
// - blank-off bit drops unlock blanking on sandcastle, keeps vertical blanking
// - without hsync the oscillator free-runs at lowest frequency
// - deviation over 4% enters search and cuts first loop currents at once
// - search retunes oscillator at a fixed controlled rate
// - on coincidence soft-lock until early next vertical period, then lock
// - frequency voltage buffer is sampled and held clear of sync disturbance
// - status pin floats in free-run, in search or under any protection condition
// - otherwise status pin shows vertical blanking only
// - blank-off bit removes unlock blanking from status pin too
// - clearing ramp enable bit forces standby: continuous blanking, pin floating
// - after ramp done and loops normal, end continuous blanking, pin shows vblank
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "sync_blank_regs.vh"

module sync_blank_lock_status #(
  parameter FMIN_PERIOD = `FMIN_PERIOD,
  parameter RAMP_CYCLES = `RAMP_CYCLES
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // sync and protection pins
  input  wire        hsync_i,
  input  wire        vsync_i,
  input  wire        flyback_in_i,
  input  wire        overvoltage_guard_in_i,
  input  wire        supply_low_i,
  input  wire        ramp_force_i,
  // picture chain outputs
  output reg  [1:0]  sandcastle_out_o,
  output reg         vert_trigger_o,
  output reg         norm_hsync_o,
  output reg         first_loop_enable_o,
  output reg  [15:0] freq_voltage_buffer_o,
  // open-drain lock status pin
  input  wire        lock_status_out_i,
  output reg         lock_status_out_o,
  output reg         lock_status_out_oe_o
);

  localparam [3:0] ST_FREE   = 4'b0001;
  localparam [3:0] ST_SEARCH = 4'b0010;
  localparam [3:0] ST_SOFT   = 4'b0100;
  localparam [3:0] ST_LOCK   = 4'b1000;

  localparam [31:0] FMIN_W   = FMIN_PERIOD;
  localparam [31:0] NOSYNC_W = 2 * FMIN_PERIOD;
  localparam [31:0] RAMP_W   = RAMP_CYCLES;
  localparam [31:0] CLAMP_W  = `CLAMP_CYCLES;
  localparam [31:0] OV_W     = `OV_CYCLES;
  localparam [15:0] FMIN_P   = FMIN_W[15:0];
  localparam [15:0] NOSYNC_P = NOSYNC_W[15:0];
  localparam [19:0] RAMP_C   = RAMP_W[19:0];
  localparam [7:0]  CLAMP_C  = CLAMP_W[7:0];
  localparam [7:0]  OV_C     = OV_W[7:0];

  // saturating up/down integrator step
  function [11:0] integ;
    input [11:0] c;
    input        up;
    begin
      if (up)
        integ = (c == 12'hFFF) ? c : c + 12'h001;
      else
        integ = (c == 12'h000) ? c : c - 12'h001;
    end
  endfunction

  // true when the two periods differ by more than 1/FREQ_TOL_DIV of the oscillator period
  function dev_big;
    input [15:0] osc;
    input [15:0] meas;
    reg   [15:0] d;
    reg   [31:0] m;
    begin
      d = (osc > meas) ? osc - meas : meas - osc;
      m = {16'h0000, d} * `FREQ_TOL_DIV;
      dev_big = m > {16'h0000, osc};
    end
  endfunction

  // input synchronisers
  reg [5:0] s1_reg;
  reg [5:0] s2_reg;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
    end else begin
      s1_reg <= {lock_status_out_i, ramp_force_i, supply_low_i, overvoltage_guard_in_i, flyback_in_i,
                 hsync_i};
      s2_reg <= s1_reg;
    end
  end
  wire h_raw  = s2_reg[0];
  wire fb_in  = s2_reg[1];
  wire ov_in  = s2_reg[2];
  wire low_in = s2_reg[3];
  wire frc_in = s2_reg[4];
  wire pin_in = s2_reg[5];

  reg [1:0] vs_reg;
  always @(posedge clk_i) begin
    if (!resetn_i)
      vs_reg <= 2'b00;
    else
      vs_reg <= {vs_reg[0], vsync_i};
  end
  wire v_raw = vs_reg[1];

  // control registers
  reg [3:0]  ctrl_reg;
  reg [7:0]  ref_reg;
  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [15:0] osc_per_reg;
  reg [15:0] osc_per_next;

  // polarity integrators and normalised sync
  reg [11:0] hpol_reg;
  reg [11:0] vpol_reg;
  reg [11:0] vint_reg;
  reg        hn_reg;
  reg        vn_reg;
  reg        vt_reg;
  wire       v_ext = (vint_reg >= {ref_reg, 4'h0});
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      hpol_reg <= 12'h800;
      vpol_reg <= 12'h800;
      vint_reg <= 12'h000;
      hn_reg   <= 1'b0;
      vn_reg   <= 1'b0;
      vt_reg   <= 1'b0;
    end else begin
      hpol_reg <= integ(hpol_reg, h_raw);
      vpol_reg <= integ(vpol_reg, v_raw);
      hn_reg   <= h_raw ^ hpol_reg[11];
      vn_reg   <= v_raw ^ vpol_reg[11];
      vint_reg <= integ(vint_reg, hn_reg);
      vt_reg   <= vn_reg | v_ext;
    end
  end
  wire hpol = hpol_reg[11];
  wire vpol = vpol_reg[11];

  reg hn_d_reg;
  reg vt_d_reg;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      hn_d_reg <= 1'b0;
      vt_d_reg <= 1'b0;
    end else begin
      hn_d_reg <= hn_reg;
      vt_d_reg <= vt_reg;
    end
  end
  wire h_rise = hn_reg & ~hn_d_reg;
  wire h_fall = ~hn_reg & hn_d_reg;
  wire v_rise = vt_reg & ~vt_d_reg;

  // sync period measurement and missing sync / flyback detection
  reg [15:0] scnt_reg;
  reg [15:0] meas_reg;
  reg [15:0] fcnt_reg;
  reg        fb_d_reg;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      scnt_reg <= 16'h0000;
      meas_reg <= FMIN_P;
      fcnt_reg <= 16'h0000;
      fb_d_reg <= 1'b0;
    end else begin
      fb_d_reg <= fb_in;
      if (h_rise) begin
        meas_reg <= scnt_reg + 16'h0001;
        scnt_reg <= 16'h0000;
      end else if (scnt_reg != NOSYNC_P)
        scnt_reg <= scnt_reg + 16'h0001;
      if (fb_in & ~fb_d_reg)
        fcnt_reg <= 16'h0000;
      else if (fcnt_reg != NOSYNC_P)
        fcnt_reg <= fcnt_reg + 16'h0001;
    end
  end
  wire no_sync = (scnt_reg == NOSYNC_P);
  wire no_fb   = (fcnt_reg == NOSYNC_P);

  // protection: guard filter, soft start ramp
  reg [7:0]  ovc_reg;
  reg [19:0] ramp_reg;
  wire ov_trip = (ovc_reg == OV_C);
  wire ramp_run = ctrl_reg[`CTRL_RAMP_BIT] & ~frc_in & ~low_in;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ovc_reg  <= 8'h00;
      ramp_reg <= 20'h00000;
    end else begin
      if (!ov_in)
        ovc_reg <= 8'h00;
      else if (!ov_trip)
        ovc_reg <= ovc_reg + 8'h01;
      if (!ramp_run)
        ramp_reg <= 20'h00000;
      else if (ramp_reg != RAMP_C)
        ramp_reg <= ramp_reg + 20'h00001;
    end
  end
  wire ramp_done = (ramp_reg == RAMP_C);
  wire prot   = ~ramp_done | no_fb | ov_trip | low_in;
  wire unlock = state_reg[0] | state_reg[1];

  // horizontal oscillator
  reg [15:0] ocnt_reg;
  wire o_tick = (ocnt_reg + 16'h0001 >= osc_per_reg);
  always @(posedge clk_i) begin
    if (!resetn_i)
      ocnt_reg <= 16'h0000;
    else if (o_tick)
      ocnt_reg <= 16'h0000;
    else
      ocnt_reg <= ocnt_reg + 16'h0001;
  end

  // lock state machine
  reg       vseen_reg;
  reg [7:0] soft_reg;
  wire dev = dev_big(osc_per_reg, meas_reg);
  always @* begin
    state_next   = state_reg;
    osc_per_next = osc_per_reg;
    case (state_reg)
      ST_FREE: begin
        osc_per_next = FMIN_P;
        if (h_rise)
          state_next = ST_SEARCH;
      end
      ST_SEARCH: begin
        if (h_rise) begin
          if (!dev)
            state_next = ST_SOFT;
          else if (osc_per_reg > meas_reg)
            osc_per_next = osc_per_reg - `SEARCH_STEP;
          else
            osc_per_next = osc_per_reg + `SEARCH_STEP;
        end
      end
      ST_SOFT: begin
        if (h_rise && dev)
          state_next = ST_SEARCH;
        else if (vseen_reg && soft_reg == `SOFT_LINES)
          state_next = ST_LOCK;
        else if (h_rise)
          osc_per_next = meas_reg;
      end
      ST_LOCK: begin
        if (h_rise && dev)
          state_next = ST_SEARCH;
        else if (h_rise)
          osc_per_next = meas_reg;
      end
      default: state_next = ST_FREE;
    endcase
    if (no_sync || prot)
      state_next = ST_FREE;
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg   <= ST_FREE;
      osc_per_reg <= FMIN_P;
      vseen_reg   <= 1'b0;
      soft_reg    <= 8'h00;
    end else begin
      state_reg   <= state_next;
      osc_per_reg <= osc_per_next;
      if (state_next != ST_SOFT) begin
        vseen_reg <= 1'b0;
        soft_reg  <= 8'h00;
      end else if (v_rise)
        vseen_reg <= 1'b1;
      else if (vseen_reg && h_rise && soft_reg != `SOFT_LINES)
        soft_reg  <= soft_reg + 8'h01;
    end
  end

  // clamp one-shot and vertical blanking
  reg [7:0]  clc_reg;
  reg [15:0] vbc_reg;
  wire cl_trig = ctrl_reg[`CTRL_CLAMP_BIT] ? h_fall : h_rise;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      clc_reg <= 8'h00;
      vbc_reg <= 16'h0000;
    end else begin
      if (cl_trig && clc_reg == 8'h00)
        clc_reg <= CLAMP_C;
      else if (clc_reg != 8'h00)
        clc_reg <= clc_reg - 8'h01;
      if (v_rise)
        vbc_reg <= ctrl_reg[`CTRL_VBLEN_BIT] ? `VBLANK_LONG : `VBLANK_SHORT;
      else if (o_tick && vbc_reg != 16'h0000)
        vbc_reg <= vbc_reg - 16'h0001;
    end
  end
  wire clamp  = (clc_reg != 8'h00);
  wire vblank = (vbc_reg != 16'h0000);
  wire cblank = prot | (unlock & ~ctrl_reg[`CTRL_BLKOFF_BIT]);

  // outputs
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      sandcastle_out_o      <= 2'b00;
      vert_trigger_o        <= 1'b0;
      norm_hsync_o          <= 1'b0;
      first_loop_enable_o   <= 1'b0;
      freq_voltage_buffer_o <= FMIN_P;
      lock_status_out_o     <= 1'b0;
      lock_status_out_oe_o  <= 1'b0;
    end else begin
      if (clamp)
        sandcastle_out_o <= 2'b10;
      else if (vblank | cblank)
        sandcastle_out_o <= 2'b01;
      else
        sandcastle_out_o <= 2'b00;
      vert_trigger_o      <= v_rise;
      norm_hsync_o        <= hn_reg;
      first_loop_enable_o <= state_next[2] | state_next[3];
      if (!hn_reg && !v_ext)
        freq_voltage_buffer_o <= osc_per_reg;
      lock_status_out_oe_o <= ~(prot | (unlock & ~ctrl_reg[`CTRL_BLKOFF_BIT]));
      lock_status_out_o    <= vblank;
    end
  end

  // register port
  wire [31:0] stat = {22'h000000, ramp_done, pin_in, vpol, hpol, cblank, prot, state_reg};
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= `CTRL_RESET;
      ref_reg  <= `REF_RESET;
      rdata_o  <= 32'h00000000;
    end else begin
      if (wr_i && addr_i == `CTRL_ADDR)
        ctrl_reg <= wdata_i[3:0];
      if (wr_i && addr_i == `REF_ADDR)
        ref_reg <= wdata_i[7:0];
      if (ov_trip)
        ctrl_reg[`CTRL_RAMP_BIT] <= 1'b0;
      if (rd_i) begin
        case (addr_i)
          `CTRL_ADDR:   rdata_o <= {28'h0000000, ctrl_reg};
          `REF_ADDR:    rdata_o <= {24'h000000, ref_reg};
          `STAT_ADDR:   rdata_o <= stat;
          `PERIOD_ADDR: rdata_o <= {16'h0000, osc_per_reg};
          default:      rdata_o <= 32'h00000000;
        endcase
      end else
        rdata_o <= 32'h00000000;
    end
  end

endmodule // sync_blank_lock_status

// ==== test/sync_blank_chk_sva.sv ====
// port assertions for the sync front end
`timescale 1ns/1ps
`include "sync_blank_regs.vh"
module sync_blank_chk #(
  parameter FMIN_PERIOD = 100
) (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        hsync_i,
  input wire [1:0]  sandcastle_out_o,
  input wire        vert_trigger_o,
  input wire        first_loop_enable_o,
  input wire [15:0] freq_voltage_buffer_o,
  input wire        lock_status_out_o,
  input wire        lock_status_out_oe_o
);
  reg [15:0] clamp_cnt;
  reg [15:0] quiet_cnt;
  reg        hs_q;
  wire       clamp = (sandcastle_out_o == 2'b10);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  always @(posedge clk_i) begin
    hs_q <= hsync_i;
    if (!resetn_i || !clamp) clamp_cnt <= 16'h0000;
    else clamp_cnt <= clamp_cnt + 16'h0001;
    if (!resetn_i || hsync_i != hs_q) quiet_cnt <= 16'h0000;
    else if (quiet_cnt != 16'hFFFF) quiet_cnt <= quiet_cnt + 16'h0001;
  end
  sc_code_a: assert property (sandcastle_out_o != 2'b11) else $error("bad sandcastle code");
  trig_pulse_a: assert property (vert_trigger_o |=> !vert_trigger_o) else $error("long trigger");
  clamp_width_a: assert property ($fell(clamp) |-> clamp_cnt == `CLAMP_CYCLES) else $error("clamp width");
  float_blank_a: assert property (!lock_status_out_oe_o [*3] |-> sandcastle_out_o != 2'b00)
    else $error("floating pin without blanking");
  pin_vblank_a: assert property (lock_status_out_oe_o && lock_status_out_o |-> sandcastle_out_o != 2'b00)
    else $error("pin blank without sandcastle");
  vblank_start_a: assert property (vert_trigger_o && lock_status_out_oe_o |-> ##[0:4] lock_status_out_o)
    else $error("no blanking after trigger");
  search_rate_a: assert property (!first_loop_enable_o && $changed(freq_voltage_buffer_o) &&
    freq_voltage_buffer_o != FMIN_PERIOD |-> freq_voltage_buffer_o == $past(freq_voltage_buffer_o) + 16'h0001 ||
    freq_voltage_buffer_o == $past(freq_voltage_buffer_o) - 16'h0001) else $error("search step size");
  free_run_a: assert property (quiet_cnt > 2 * FMIN_PERIOD + 8 |->
    !first_loop_enable_o && freq_voltage_buffer_o == FMIN_PERIOD) else $error("no free run");
  cover property ($fell(clamp));
  cover property ($rose(first_loop_enable_o));
  cover property (vert_trigger_o && lock_status_out_oe_o);
endmodule // sync_blank_chk
bind sync_blank_lock_status sync_blank_chk #(.FMIN_PERIOD(FMIN_PERIOD)) chk (.clk_i, .resetn_i, .hsync_i,
  .sandcastle_out_o, .vert_trigger_o, .first_loop_enable_o, .freq_voltage_buffer_o, .lock_status_out_o,
  .lock_status_out_oe_o);

// ==== test/sync_source.sv ====
// sync source, flyback and microcontroller pull-up
`timescale 1ns/1ps
module sync_source (
  input  wire clk_i,
  input  wire run_i,
  input  wire neg_i,
  input  wire oe_i,
  input  wire drv_i,
  output reg  hsync_o,
  output reg  vsync_o,
  output reg  flyback_o,
  output wire pin_o
);
  integer hcnt = 0;
  integer line = 0;
  integer fcnt = 0;
  initial hsync_o = 1'b0;
  initial vsync_o = 1'b0;
  initial flyback_o = 1'b0;
  assign pin_o = oe_i ? drv_i : 1'b1;
  always @(posedge clk_i) begin
    hcnt <= (hcnt == 89) ? 0 : hcnt + 1;
    if (hcnt == 89) line <= (line == 63) ? 0 : line + 1;
    hsync_o <= (run_i && hcnt < 12) ^ neg_i;
    vsync_o <= (run_i && line < 3) ^ neg_i;
    fcnt <= (fcnt == 94) ? 0 : fcnt + 1;
    flyback_o <= (fcnt < 8);
  end
endmodule // sync_source

// ==== test/tb_sync_blank_lock_status.sv ====
// self-checking bench for the sync front end
`timescale 1ns/1ps
`include "sync_blank_regs.vh"
module tb_sync_blank_lock_status;
  reg         clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, run = 0, neg = 0;
  reg  [7:0]  addr_i = 0;
  reg  [31:0] wdata_i = 0, r, d;
  reg  [2:0]  prot_in = 0;
  wire [31:0] rdata_o;
  wire [15:0] fvb;
  wire [1:0]  sc;
  wire        hs, vs, fb, vt, nh, fle, drv, oe, pin;
  integer     err_total = 0, total_checks = 0, cycles = 0, i, n, hi;
  always #12.5 clk_i = ~clk_i;
  sync_blank_lock_status #(.FMIN_PERIOD(100), .RAMP_CYCLES(50)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .hsync_i(hs), .vsync_i(vs), .flyback_in_i(fb), .overvoltage_guard_in_i(prot_in[0]),
    .supply_low_i(prot_in[1]), .ramp_force_i(prot_in[2]), .sandcastle_out_o(sc), .vert_trigger_o(vt),
    .norm_hsync_o(nh), .first_loop_enable_o(fle), .freq_voltage_buffer_o(fvb), .lock_status_out_i(pin),
    .lock_status_out_o(drv), .lock_status_out_oe_o(oe));
  sync_source src (.clk_i(clk_i), .run_i(run), .neg_i(neg), .oe_i(oe), .drv_i(drv), .hsync_o(hs),
    .vsync_o(vs), .flyback_o(fb), .pin_o(pin));
  function ok_f(input [15:0] p);
    ok_f = ((p > 90) ? p - 90 : 90 - p) * 25 <= 90;
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    r = rdata_o;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 95000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    r = $urandom(32'hF4EB);
    neg = $urandom % 2;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(2);
    rd(`CTRL_ADDR);
    check(r, `CTRL_RESET);
    rd(`REF_ADDR);
    check(r, `REF_RESET);
    rd(8'h10);
    check(r, 32'h0);
    wr(`STAT_ADDR, 32'hFFFFFFFF);
    rd(`STAT_ADDR);
    check(r[4:0], 5'h11);
    check(oe, 0);
    wr(`CTRL_ADDR, 32'hFFFFFFF7);
    rd(`CTRL_ADDR);
    check(r, 32'h7);
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      wr(`REF_ADDR, d);
      rd(`REF_ADDR);
      check(r, d & 32'hFF);
    end
    wr(`REF_ADDR, `REF_RESET);
    run <= 1'b1;
    wr(`CTRL_ADDR, 32'h8);
    cyc(6000);
    hi = 0;
    for (i = 0; i < 900; i = i + 1) begin
      @(negedge clk_i);
      hi = hi + nh;
    end
    check(hi, 120);
    r = 0;
    for (n = 0; n < 300 && r[3:0] !== 4'h8; n = n + 1) begin
      cyc(100);
      rd(`STAT_ADDR);
    end
    check(r[4:0], 5'h08);
    check(fle, 1);
    check(oe, 1);
    check(pin, drv);
    check(ok_f(fvb), 1);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`CTRL_ADDR, 32'h8 | i);
      cyc(100);
      for (n = 0; n < 200 && sc === 2'b10; n = n + 1) @(negedge clk_i);
      for (n = 0; n < 200 && sc !== 2'b10; n = n + 1) @(negedge clk_i);
      check(nh, i == 0);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(`CTRL_ADDR, 32'h8 | (i << 1));
      for (n = 0; n < 7000 && drv; n = n + 1) @(negedge clk_i);
      for (n = 0; n < 7000 && !drv; n = n + 1) @(negedge clk_i);
      for (n = 0; n < 7000 && drv; n = n + 1) @(negedge clk_i);
      d = (i ? `VBLANK_LONG : `VBLANK_SHORT) * fvb;
      check(n + fvb >= d && n <= d + fvb, 1);
    end
    hi = 0;
    for (i = 0; i < 5760; i = i + 1) begin
      @(negedge clk_i);
      hi = hi + vt;
    end
    check(hi, 1);
    run <= 1'b0;
    cyc(4400);
    rd(`STAT_ADDR);
    check(r[4:0], 5'h01);
    check(fvb, 100);
    check(oe, 0);
    check(sc !== 2'b00, 1);
    wr(`CTRL_ADDR, 32'hC);
    cyc(5);
    check(oe, 1);
    check(sc, 2'b00);
    wr(`CTRL_ADDR, 32'h4);
    cyc(5);
    check(oe, 0);
    check(sc !== 2'b00, 1);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CTRL_ADDR, 32'hC);
      cyc(150);
      check(oe, 1);
      @(posedge clk_i);
      prot_in <= 3'b001 << i;
      cyc(100 + $urandom % 50);
      check(oe, 0);
      rd(`STAT_ADDR);
      check(r[4], 1);
      @(posedge clk_i);
      prot_in <= 3'b000;
      rd(`CTRL_ADDR);
      check(r[3], i != 0);
    end
    wrap_up;
  end
endmodule // tb_sync_blank_lock_status
